// file: rtl/sac_pkg.sv
`default_nettype none
package sac_pkg;
	localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h34;
	localparam logic [7:0] ADDR_CTRL_TIMING_STATUS = 8'h35;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h36;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h37;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// adc_ctrl_primary fields
	localparam int GO_BIT = 7;
	localparam int MODE_HI = 6;
	localparam int MODE_LO = 5;
	localparam int AIN_EN_BIT = 4;
	localparam int CHAN_HI = 3;
	// adc_ctrl_timing_status fields
	localparam int DONE_BIT = 7;
	localparam int BUSY_BIT = 6;
	localparam int TIME_HI = 2;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [3:0] CHAN_LAST = 4'h7;
	localparam logic [2:0] TIME_LAST = 3'h4;
	// conversion times in core cycles, base code and shifts
	localparam int CONV_BASE_CYC = 39;
	// start plus store latency: worst figures per code pair
	localparam int LAT_00X = 10;
	localparam int LAT_01X = 32;
	localparam int LAT_10X = 128;
	// latency actually used: one cycle to start, one to store
	localparam logic [11:0] LAT_USED = 12'h002;
	localparam int CNT_W = 12;
	localparam int RES_W = 10;
	typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_STORE} sac_state_type;
endpackage
`default_nettype wire

// file: rtl/sac_conv_if.sv
`default_nettype none
interface sac_conv_if;
	logic start;
	logic abort;
	logic [2:0] time_code;
	logic done;
	modport ctl (output start, output abort, output time_code, input done);
	modport tmr (input start, input abort, input time_code, output done);
endinterface
`default_nettype wire

// file: rtl/sac_conv_timer.sv
`default_nettype none
// counts the selected conversion length and pulses done at its end
module sac_conv_timer (
	input wire logic clk_i,
	input wire logic rstn_i,
	sac_conv_if.tmr cv
);
	logic [sac_pkg::CNT_W-1:0] cnt_r;
	logic run_r;
	logic [sac_pkg::CNT_W-1:0] len;
	logic [sac_pkg::CNT_W-1:0] base;
	assign base = sac_pkg::CNT_W'(sac_pkg::CONV_BASE_CYC);
	// 39 << code gives 39,78,156,312,624
	assign len = base << cv.time_code;
	always_ff @(posedge clk_i) begin
		if (!rstn_i || cv.abort) begin
			run_r <= 1'b0;
			cnt_r <= '0;
			cv.done <= 1'b0;
		end else begin
			cv.done <= 1'b0;
			if (cv.start) begin
				run_r <= 1'b1;
				cnt_r <= len - 1'b1;
			end else if (run_r) begin
				if (cnt_r == '0) begin
					run_r <= 1'b0;
					cv.done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/sac_regs.sv
// Overview of operation
// - mode: off, single, repeat; 10 reserved
// - channel codes 0..7 pick inputs
// - input enable bit gates all inputs
// - go bit starts, self clears, reads 0
// - low power clears go, mode, enable
// - done flag high after conversion ends
// - busy flag high while converting
// - time code sets 39..624 cycles
// - status bits 3..5 read zero
// - high result read or restart clears done
// - low power clears flags, results, aborts
// - ten bit result split low/high
// - mode off clears results
// - repeat: split read keeps old result
// - start plus store latency bounded
// - completion stores, sets done, irqs
// - busy set on start, cleared end/stop
// - repeat restarts automatically
// - mode off stops at once, clears flags
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
module sac_regs (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic low_power_i,
	input wire logic [9:0] sar_value_i,
	output logic [7:0] rdata_o,
	output logic [3:0] channel_sel_o,
	output logic analog_in_en_o,
	output logic sample_o,
	output logic conv_done_irq_o
);
	// ************************************************
	// state
	// ************************************************
	sac_conv_if cv ();
	sac_pkg::sac_state_type state_r;
	sac_pkg::sac_state_type state_nxt;
	logic [1:0] op_mode_sel_r;
	logic analog_in_en_r;
	logic [3:0] channel_sel_r;
	logic [2:0] time_sel_r;
	logic conv_done_flag_r;
	logic conv_busy_flag_r;
	logic [9:0] result_r;
	logic low_read_r;
	logic go_pend_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic sample_r;

	// ************************************************
	// decode
	// ************************************************
	logic wr_ctrl;
	logic wr_time;
	logic rd_low;
	logic rd_high;
	logic [1:0] wr_mode;
	logic wr_go;
	logic mode_off_wr;
	logic abort;
	logic start_now;
	logic store;
	logic repeat_mode;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;
	logic [7:0] rd_mux;
	assign wr_ctrl = wr_i && addr_i == sac_pkg::ADDR_CTRL_PRIMARY;
	assign wr_time = wr_i && addr_i == sac_pkg::ADDR_CTRL_TIMING_STATUS;
	assign rd_low = rd_i && addr_i == sac_pkg::ADDR_RESULT_LOW;
	assign rd_high = rd_i && addr_i == sac_pkg::ADDR_RESULT_HIGH;
	assign wr_mode = wdata_i[sac_pkg::MODE_HI:sac_pkg::MODE_LO];
	assign wr_go = wr_ctrl && wdata_i[sac_pkg::GO_BIT];
	assign mode_off_wr = wr_ctrl && wr_mode == sac_pkg::MODE_OFF;
	assign abort = low_power_i || mode_off_wr;
	assign repeat_mode = op_mode_sel_r == sac_pkg::MODE_REPEAT;
	// go is honoured only in a legal mode with a legal channel/time
	assign start_now = go_pend_r && !abort &&
		(op_mode_sel_r == sac_pkg::MODE_SINGLE || repeat_mode) &&
		channel_sel_r <= sac_pkg::CHAN_LAST &&
		time_sel_r <= sac_pkg::TIME_LAST && state_r == sac_pkg::SAC_IDLE;
	// a split read in single or repeat mode, or a low result read during the store
	// cycle, drops the new value; the irq is withheld with it
	assign store = state_r == sac_pkg::SAC_STORE && !abort &&
		!(low_read_r && !rd_high) && !rd_low;
	assign cv.start = start_now ||
		(state_r == sac_pkg::SAC_STORE && repeat_mode && !abort);
	assign cv.abort = abort;
	assign cv.time_code = time_sel_r;
	// go bit always reads back 0
	assign ctrl_rd = {1'b0, op_mode_sel_r, analog_in_en_r, channel_sel_r};
	assign stat_rd = {conv_done_flag_r, conv_busy_flag_r, 3'h0, time_sel_r};
	assign rd_mux = (addr_i == sac_pkg::ADDR_CTRL_PRIMARY) ? ctrl_rd :
		(addr_i == sac_pkg::ADDR_CTRL_TIMING_STATUS) ? stat_rd :
		(addr_i == sac_pkg::ADDR_RESULT_LOW) ? result_r[7:0] :
		(addr_i == sac_pkg::ADDR_RESULT_HIGH) ? {6'h00, result_r[9:8]} :
		sac_pkg::RESET_VALUE;

	sac_conv_timer u_timer (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.cv(cv.tmr)
	);

	// ************************************************
	// sequencer
	// ************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sac_pkg::SAC_IDLE: begin
				if (start_now) state_nxt = sac_pkg::SAC_CONV;
			end
			sac_pkg::SAC_CONV: begin
				if (cv.done) state_nxt = sac_pkg::SAC_STORE;
			end
			sac_pkg::SAC_STORE: begin
				state_nxt = repeat_mode ? sac_pkg::SAC_CONV : sac_pkg::SAC_IDLE;
			end
			default: state_nxt = sac_pkg::SAC_IDLE;
		endcase
		if (abort) state_nxt = sac_pkg::SAC_IDLE;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) state_r <= sac_pkg::SAC_IDLE;
		else state_r <= state_nxt;
	end

	// ************************************************
	// control registers
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (!rstn_i || low_power_i) begin
			op_mode_sel_r <= sac_pkg::MODE_OFF;
			analog_in_en_r <= 1'b0;
			go_pend_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				op_mode_sel_r <= wr_mode;
				analog_in_en_r <= wdata_i[sac_pkg::AIN_EN_BIT];
			end
			// go waits one cycle for the mode to settle, then clears
			if (wr_go) go_pend_r <= 1'b1;
			else go_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			channel_sel_r <= 4'h0;
			time_sel_r <= 3'h0;
		end else begin
			if (wr_ctrl) channel_sel_r <= wdata_i[sac_pkg::CHAN_HI:0];
			if (wr_time) time_sel_r <= wdata_i[sac_pkg::TIME_HI:0];
		end
	end

	// ************************************************
	// flags and result
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (!rstn_i || abort) begin
			conv_busy_flag_r <= 1'b0;
			conv_done_flag_r <= 1'b0;
			result_r <= 10'h000;
			low_read_r <= 1'b0;
		end else begin
			if (start_now) conv_busy_flag_r <= 1'b1;
			else if (state_r == sac_pkg::SAC_STORE && !repeat_mode)
				conv_busy_flag_r <= 1'b0;
			if (store) begin
				result_r <= sar_value_i;
				conv_done_flag_r <= 1'b1;
			end else if (rd_high || start_now) begin
				conv_done_flag_r <= 1'b0;
			end
			if (rd_low) low_read_r <= 1'b1;
			else if (rd_high) low_read_r <= 1'b0;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_r <= sac_pkg::RESET_VALUE;
			irq_r <= 1'b0;
			sample_r <= 1'b0;
		end else begin
			rdata_r <= rd_i ? rd_mux : sac_pkg::RESET_VALUE;
			irq_r <= store;
			sample_r <= state_r == sac_pkg::SAC_CONV && cv.done;
		end
	end

	assign rdata_o = rdata_r;
	assign channel_sel_o = channel_sel_r;
	assign analog_in_en_o = analog_in_en_r;
	assign sample_o = sample_r;
	assign conv_done_irq_o = irq_r;
endmodule
`default_nettype wire

// file: test/sac_regs_asserts.sv
`default_nettype none
// ****
// port checks of the converter control block
// ****
module sac_regs_asserts (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic low_power_i,
	input wire logic [7:0] rdata_o,
	input wire logic [3:0] channel_sel_o,
	input wire logic analog_in_en_o,
	input wire logic sample_o,
	input wire logic conv_done_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic ctl_hit = wr_i && addr_i == 8'h34;
	wire logic ctl_wr = ctl_hit && !low_power_i;
	// a go is only legal from idle, so no result may follow too soon
	sequence s_go;
		ctl_wr && wdata_i[7];
	endsequence
	sequence s_quiet;
		!conv_done_irq_o [*8];
	endsequence
	AST_IRQ_PULSE: assert property (conv_done_irq_o |=> !conv_done_irq_o)
		else $error("irq wider than one cycle");
	AST_STS_ZERO: assert property (rd_i && addr_i == 8'h35 |=> rdata_o[5:3] == 3'h0)
		else $error("status bits 5..3 not zero");
	AST_HIGH_ZERO: assert property (rd_i && addr_i == 8'h37 |=> rdata_o[7:2] == 6'h00)
		else $error("high result bits 7..2 not zero");
	AST_GO_READ0: assert property (rd_i && addr_i == 8'h34 && !$past(wr_i) |=> !rdata_o[7])
		else $error("go bit read as one");
	AST_LP_CLEAR: assert property (low_power_i |=> !analog_in_en_o && !conv_done_irq_o)
		else $error("low power left state set");
	AST_AIN_WR: assert property (ctl_wr |=> analog_in_en_o == $past(wdata_i[4]))
		else $error("input enable not taken");
	AST_CHAN_WR: assert property (ctl_wr && wdata_i[3:0] <= 4'h7 |=> channel_sel_o == $past(wdata_i[3:0]))
		else $error("channel not taken");
	AST_CHAN_HOLD: assert property (!ctl_hit && !low_power_i |=> $stable(channel_sel_o))
		else $error("channel moved without a write");
	AST_GO_QUIET: assert property (s_go |=> s_quiet)
		else $error("result too soon after go");
	AST_OFF_QUIET: assert property (ctl_wr && wdata_i[6:5] == 2'h0 |=> s_quiet)
		else $error("result after stop");
	// a stored result always follows the end of a timed conversion
	AST_SAMPLE_IRQ: assert property (conv_done_irq_o |-> $past(sample_o))
		else $error("irq without a finished conversion");
endmodule
`default_nettype wire

// file: test/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rstn_i, wr_i, rd_i, low_power_i;
	logic [7:0] addr_i, wdata_i, rdata_o;
	logic [9:0] sar_value_i;
	logic [3:0] channel_sel_o;
	logic analog_in_en_o, sample_o, conv_done_irq_o;
	int errors, n_tests, cyc, n_irq, k, m, lim;
	sac_regs uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.low_power_i(low_power_i), .sar_value_i(sar_value_i),
		.rdata_o(rdata_o), .channel_sel_o(channel_sel_o),
		.analog_in_en_o(analog_in_en_o), .sample_o(sample_o),
		.conv_done_irq_o(conv_done_irq_o));
	initial begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ****
	// bus tasks and run control
	// ****
	task automatic close_out();
		if (errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// the longest conversion is 624 cycles; the ceiling leaves ample room
	always @(posedge clk_i) begin
		cyc++;
		if (conv_done_irq_o === 1'b1) n_irq++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i);
		rd_i <= 1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 0;
		#1 `CHK("rdata", e, rdata_o)
	endtask
	// k counts edges from the wait_irq call to the irq, plus one
	task automatic wait_irq();
		k = 1;
		do begin
			@(posedge clk_i);
			#1 k++;
		end while (conv_done_irq_o !== 1'b1 && k < 2000);
	endtask
	task automatic quiet();
		m = n_irq;
		repeat (60) @(posedge clk_i);
		`CHK("irq count", m, n_irq)
	endtask
	initial begin
		{rstn_i, wr_i, rd_i, low_power_i, addr_i, wdata_i} = '0;
		sar_value_i = 10'h000;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1;
		for (int a = 8'h34; a < 8'h39; a++) rd(8'(a), 8'h00);
		wr(8'h34, 8'h33);
		rd(8'h34, 8'h33);
		`CHK("channel", 4'h3, channel_sel_o)
		`CHK("enable", 1'b1, analog_in_en_o)
		wr(8'h35, 8'h34);
		rd(8'h35, 8'h04);
		for (int c = 0; c < 5; c++) begin
			sar_value_i <= 10'h2a5 ^ 10'(c);
			wr(8'h35, 8'(c));
			wr(8'h34, 8'hb3);
			rd(8'h35, 8'h40 | 8'(c));
			rd(8'h34, 8'h33);
			wait_irq();
			lim = 39 << c;
			m = c < 2 ? 10 : (c < 4 ? 32 : 128);
			`CHK("cycles", 1'b1, k >= lim && k <= lim + m)
			rd(8'h35, 8'h80 | 8'(c));
			rd(8'h36, 8'ha5 ^ 8'(c));
			rd(8'h37, 8'h02);
			rd(8'h35, 8'(c));
		end
		wr(8'h35, 8'h00);
		sar_value_i <= 10'h155;
		wr(8'h34, 8'hf3);
		wait_irq();
		sar_value_i <= 10'h0ff;
		rd(8'h36, 8'h55);
		quiet();
		rd(8'h37, 8'h01);
		wait_irq();
		`CHK("restart", 1'b1, k < 60)
		rd(8'h36, 8'hff);
		wr(8'h34, 8'h13);
		rd(8'h35, 8'h00);
		rd(8'h36, 8'h00);
		quiet();
		wr(8'h34, 8'hb3);
		wait_irq();
		wr(8'h34, 8'hb3);
		rd(8'h35, 8'h40);
		low_power_i <= 1;
		repeat (2) @(posedge clk_i);
		low_power_i <= 0;
		rd(8'h34, 8'h03);
		rd(8'h35, 8'h00);
		rd(8'h36, 8'h00);
		quiet();
		wr(8'h34, 8'hd3);
		rd(8'h35, 8'h00);
		quiet();
		close_out();
	end
endmodule
bind sac_regs sac_regs_asserts chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.low_power_i(low_power_i), .rdata_o(rdata_o),
	.channel_sel_o(channel_sel_o), .analog_in_en_o(analog_in_en_o),
	.sample_o(sample_o), .conv_done_irq_o(conv_done_irq_o));
`default_nettype wire
